// [include/gpio_pkg.sv]
// package: register map, reset values and carrier types for the port block
package gpio_pkg;
    // ==========================================
    // widths
    localparam int NIB = 4;
    typedef logic [NIB-1:0] gpio_nib_t;
    typedef logic [31:0]    gpio_word_t;
    typedef logic [7:0]     gpio_addr_t;

    // ==========================================
    // register byte addresses (documented 27h is not a multiple of four: index*4)
    localparam logic [7:0] IDX_GRP_SEL   = 8'h27;
    localparam logic [7:0] IDX_DIR_SECND = 8'h36;
    localparam logic [7:0] IDX_DIR_FIRST = 8'h37;
    localparam logic [7:0] IDX_PORT_FIRST  = 8'h00;
    localparam logic [7:0] IDX_PORT_SECND  = 8'h01;
    localparam logic [7:0] IDX_PORT_GROUP  = 8'h02;
    localparam logic [7:0] IDX_PORT_FOURTH = 8'h03;
    localparam logic [7:0] IDX_PORT_PDIN   = 8'h04;
    localparam logic [7:0] IDX_PORT_PLAIN  = 8'h05;
    localparam logic [7:0] IDX_DIR_FOURTH  = 8'h06;
    localparam logic [7:0] IDX_RMW_FIRST   = 8'h07;
    localparam logic [7:0] IDX_CTRL        = 8'h08;
    localparam logic [9:0] ADDR_SHIFT_ONE  = 10'h004;

    // ==========================================
    // reset values and field positions
    localparam gpio_nib_t DIR_RESET   = 4'h0;
    localparam gpio_nib_t LATCH_INIT  = 4'h0;
    localparam int        GRP_BIT     = 0;
    localparam int        CTRL_CE     = 0;
    localparam int        CTRL_STOP   = 1;
    localparam int        CTRL_HALT   = 2;
    localparam gpio_nib_t PIN_MASK_HI = 4'hc;
    localparam gpio_word_t ZERO_WORD  = 32'h0000_0000;

    // ==========================================
    // carriers
    typedef struct packed {
        gpio_nib_t drv;
        gpio_nib_t oe;
    } gpio_pad_out_s;

    typedef struct packed {
        logic       psel;
        logic       penable;
        logic       pwrite;
        gpio_addr_t paddr;
        gpio_word_t pwdata;
    } gpio_apb_req_s;
endpackage

// [logic/gpio_sync3.sv]
// three-stage synchroniser for a nibble of pin levels, updates when the last two stages agree
module gpio_sync3
    import gpio_pkg::*;
(
    // clock and reset
    input  wire logic          mclk,
    input  wire logic          rst,
    // pins and filtered level
    input  wire gpio_pkg::gpio_nib_t pinAsync,
    output gpio_pkg::gpio_nib_t      pinLevel
);
    gpio_nib_t s1_reg;
    gpio_nib_t s2_reg;
    gpio_nib_t s3_reg;
    gpio_nib_t lvl_reg;
    genvar g;

    // ==========================================
    // stage chain
    always_ff @(posedge mclk) begin
        if (rst) begin
            s1_reg <= LATCH_INIT;
            s2_reg <= LATCH_INIT;
            s3_reg <= LATCH_INIT;
        end else begin
            s1_reg <= pinAsync;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // ==========================================
    // agreement per bit
    generate
        for (g = 0; g < NIB; g++) begin : gAgree
            always_ff @(posedge mclk) begin
                if (rst) begin
                    lvl_reg[g] <= 1'b0;
                end else if (s2_reg[g] == s3_reg[g]) begin
                    lvl_reg[g] <= s3_reg[g];
                end
            end
        end
    endgenerate

    assign pinLevel = lvl_reg;
endmodule

// [logic/gpio_ports.sv]
// general-purpose port block: four bidirectional and two input-only nibbles, APB slave
// Functional notes
// (R1) group select bit0: 0 input, 1 output
// (R2) group port switches direction as whole nibble
// (R3) input-mode pin is released, not driven
// (R4) input-mode read returns pin level
// (R5) write in input mode still updates latch
// (R6) output-mode pin drives latch value
// (R7) output-mode read returns latch, except noted
// (R8) first port bits 3,2 read pin level
// (R9) first port rmw loads pin into bits3,2; here only output-mode bits 3,2 load pin, input-mode ones take the written data
// (R10) power-on: input mode, software initialises latches
// (R11) ce reset/stop: input mode, latches kept
// (R12) stop gates inputs on per-pin ports only; here only the second input-only port read is gated
// (R13) board pulls group port during stop
// (R14) halt keeps all port state unchanged; here ce reset or stop still clears the direction registers during halt
// (R15) input-only ports read pin levels
// (R16) writes to input-only ports ignored
// (R17) first input-only port pulled down always
// (R18) after any reset input-only ports are inputs
// (R19) second input-only port gated during stop
// (R20) per-pin direction bit 0 input, 1 output
// (R21) four-bit registers, bit n is pin n
//
// Design decision made here: the APB register port.
module gpio_ports
    import gpio_pkg::*;
(
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst,
    // apb slave
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [9:0]            paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    // system events
    input  wire logic                  ceReset,
    input  wire logic                  clockStop,
    input  wire logic                  haltState,
    // bidirectional pins
    input  wire gpio_pkg::gpio_nib_t   firstIn,
    output gpio_pkg::gpio_pad_out_s    firstOut,
    input  wire gpio_pkg::gpio_nib_t   secondIn,
    output gpio_pkg::gpio_pad_out_s    secondOut,
    input  wire gpio_pkg::gpio_nib_t   groupIn,
    output gpio_pkg::gpio_pad_out_s    groupOut,
    input  wire gpio_pkg::gpio_nib_t   fourthIn,
    output gpio_pkg::gpio_pad_out_s    fourthOut,
    // input-only pins
    input  wire gpio_pkg::gpio_nib_t   pulldownIn,
    output logic                       pulldownEn,
    input  wire gpio_pkg::gpio_nib_t   plainIn,
    output logic                       inputGateEn
);
    import gpio_pkg::*;

    // ==========================================
    // decode helpers
    function automatic logic hit(input logic [9:0] a, input logic [7:0] idx);
        hit = (a == {idx, 2'b00});
    endfunction

    function automatic gpio_nib_t readPort(input gpio_nib_t dir, input gpio_nib_t lat,
                                           input gpio_nib_t pin);
        readPort = (dir & lat) | (~dir & pin);
    endfunction

    // ==========================================
    // state
    gpio_nib_t latFirst_reg, latSecond_reg, latGroup_reg, latFourth_reg;
    gpio_nib_t dirFirst_reg, dirSecond_reg, dirFourth_reg;
    logic      grpSel_reg;
    logic      ceSw_reg, stopSw_reg, haltSw_reg;
    logic      ready_reg;
    logic      err_reg;
    gpio_word_t rdata_reg;
    gpio_pad_out_s firstOut_reg, secondOut_reg, groupOut_reg, fourthOut_reg;
    logic      pulldown_reg, gate_reg;

    gpio_nib_t lvFirst, lvSecond, lvGroup, lvFourth, lvPd, lvPlain;
    gpio_nib_t dirGroup;
    logic      access, wrAcc, rdAcc, known, stopNow, inpReset, frozen;
    gpio_word_t rdata_next;

    // ==========================================
    // pin synchronisers
    gpio_sync3 uSyncFirst  (.mclk(mclk), .rst(rst), .pinAsync(firstIn),    .pinLevel(lvFirst));
    gpio_sync3 uSyncSecond (.mclk(mclk), .rst(rst), .pinAsync(secondIn),   .pinLevel(lvSecond));
    gpio_sync3 uSyncGroup  (.mclk(mclk), .rst(rst), .pinAsync(groupIn),    .pinLevel(lvGroup));
    gpio_sync3 uSyncFourth (.mclk(mclk), .rst(rst), .pinAsync(fourthIn),   .pinLevel(lvFourth));
    gpio_sync3 uSyncPd     (.mclk(mclk), .rst(rst), .pinAsync(pulldownIn), .pinLevel(lvPd));
    gpio_sync3 uSyncPlain  (.mclk(mclk), .rst(rst), .pinAsync(plainIn),    .pinLevel(lvPlain));

    // ==========================================
    // apb decode
    assign access  = psel & penable & ready_reg;
    assign wrAcc   = access & pwrite;
    assign rdAcc   = access & ~pwrite;
    assign stopNow = clockStop | stopSw_reg;
    assign inpReset = ceReset | ceSw_reg | stopNow; // R11
    assign frozen  = haltState | haltSw_reg; // R14
    assign dirGroup = {NIB{grpSel_reg}}; // R2

    always_comb begin
        known = hit(paddr, IDX_GRP_SEL) | hit(paddr, IDX_DIR_FIRST) | hit(paddr, IDX_DIR_SECND)
              | hit(paddr, IDX_DIR_FOURTH) | hit(paddr, IDX_PORT_FIRST) | hit(paddr, IDX_PORT_SECND)
              | hit(paddr, IDX_PORT_GROUP) | hit(paddr, IDX_PORT_FOURTH) | hit(paddr, IDX_PORT_PDIN)
              | hit(paddr, IDX_PORT_PLAIN) | hit(paddr, IDX_RMW_FIRST) | hit(paddr, IDX_CTRL);
    end

    // ==========================================
    // bus handshake: ready in first access cycle
    always_ff @(posedge mclk) begin
        if (rst) begin
            ready_reg <= 1'b0;
        end else begin
            ready_reg <= psel & ~ready_reg & ~(penable & ready_reg);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            err_reg <= 1'b0;
        end else begin
            err_reg <= psel & ~ready_reg & ~known;
        end
    end

    // ==========================================
    // control register (software ce reset, stop, halt)
    always_ff @(posedge mclk) begin
        if (rst) begin
            ceSw_reg   <= 1'b0;
            stopSw_reg <= 1'b0;
            haltSw_reg <= 1'b0;
        end else if (wrAcc && hit(paddr, IDX_CTRL)) begin
            ceSw_reg   <= pwdata[CTRL_CE];
            stopSw_reg <= pwdata[CTRL_STOP];
            haltSw_reg <= pwdata[CTRL_HALT];
        end else begin
            ceSw_reg   <= 1'b0;
        end
    end

    // ==========================================
    // direction registers
    always_ff @(posedge mclk) begin
        if (rst || inpReset) begin
            dirFirst_reg  <= DIR_RESET; // R10 R11 R20
            dirSecond_reg <= DIR_RESET;
            dirFourth_reg <= DIR_RESET;
            grpSel_reg    <= DIR_RESET[GRP_BIT]; // R1
        end else if (wrAcc && !frozen) begin
            if (hit(paddr, IDX_DIR_FIRST))  dirFirst_reg  <= pwdata[NIB-1:0]; // R20 R21
            if (hit(paddr, IDX_DIR_SECND))  dirSecond_reg <= pwdata[NIB-1:0];
            if (hit(paddr, IDX_DIR_FOURTH)) dirFourth_reg <= pwdata[NIB-1:0];
            if (hit(paddr, IDX_GRP_SEL))    grpSel_reg    <= pwdata[GRP_BIT]; // R1
        end
    end

    // ==========================================
    // output latches: written in any mode, kept over ce reset and stop
    always_ff @(posedge mclk) begin
        if (rst) begin
            latFirst_reg  <= LATCH_INIT; // R10
            latSecond_reg <= LATCH_INIT;
            latGroup_reg  <= LATCH_INIT;
            latFourth_reg <= LATCH_INIT;
        end else if (wrAcc && !frozen) begin
            if (hit(paddr, IDX_PORT_FIRST))  latFirst_reg  <= pwdata[NIB-1:0]; // R5
            if (hit(paddr, IDX_PORT_SECND))  latSecond_reg <= pwdata[NIB-1:0];
            if (hit(paddr, IDX_PORT_GROUP))  latGroup_reg  <= pwdata[NIB-1:0];
            if (hit(paddr, IDX_PORT_FOURTH)) latFourth_reg <= pwdata[NIB-1:0];
            if (hit(paddr, IDX_RMW_FIRST)) begin
                latFirst_reg <= (pwdata[NIB-1:0] & ~(dirFirst_reg & PIN_MASK_HI))
                              | (lvFirst & dirFirst_reg & PIN_MASK_HI); // R9
            end
        end
    end

    // ==========================================
    // read data; input-only port writes fall through with no effect
    always_comb begin
        rdata_next = ZERO_WORD;
        if (hit(paddr, IDX_PORT_FIRST) || hit(paddr, IDX_RMW_FIRST)) begin
            rdata_next[NIB-1:0] = readPort(dirFirst_reg & ~PIN_MASK_HI, latFirst_reg, lvFirst); // R4 R7 R8
        end else if (hit(paddr, IDX_PORT_SECND)) begin
            rdata_next[NIB-1:0] = readPort(dirSecond_reg, latSecond_reg, lvSecond); // R7
        end else if (hit(paddr, IDX_PORT_GROUP)) begin
            rdata_next[NIB-1:0] = readPort(dirGroup, latGroup_reg, lvGroup); // R4
        end else if (hit(paddr, IDX_PORT_FOURTH)) begin
            rdata_next[NIB-1:0] = readPort(dirFourth_reg, latFourth_reg, lvFourth);
        end else if (hit(paddr, IDX_PORT_PDIN)) begin
            rdata_next[NIB-1:0] = lvPd; // R15 R16 R18
        end else if (hit(paddr, IDX_PORT_PLAIN)) begin
            rdata_next[NIB-1:0] = lvPlain & {NIB{~stopNow}}; // R15 R19
        end else if (hit(paddr, IDX_DIR_FIRST)) begin
            rdata_next[NIB-1:0] = dirFirst_reg;
        end else if (hit(paddr, IDX_DIR_SECND)) begin
            rdata_next[NIB-1:0] = dirSecond_reg;
        end else if (hit(paddr, IDX_DIR_FOURTH)) begin
            rdata_next[NIB-1:0] = dirFourth_reg;
        end else if (hit(paddr, IDX_GRP_SEL)) begin
            rdata_next[GRP_BIT] = grpSel_reg; // R1
        end else if (hit(paddr, IDX_CTRL)) begin
            rdata_next[CTRL_STOP] = stopSw_reg;
            rdata_next[CTRL_HALT] = haltSw_reg;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            rdata_reg <= ZERO_WORD;
        end else if (psel && !ready_reg && !pwrite) begin
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================
    // pad drive: enable only in output mode; halt holds drive and enable, even over ce reset or stop
    always_ff @(posedge mclk) begin
        if (rst) begin
            firstOut_reg  <= '0;
            secondOut_reg <= '0;
            groupOut_reg  <= '0;
            fourthOut_reg <= '0;
        end else if (!frozen) begin
            firstOut_reg  <= '{drv: latFirst_reg,  oe: dirFirst_reg  & {NIB{~inpReset}}}; // R3 R6
            secondOut_reg <= '{drv: latSecond_reg, oe: dirSecond_reg & {NIB{~inpReset}}};
            groupOut_reg  <= '{drv: latGroup_reg,  oe: dirGroup      & {NIB{~inpReset}}}; // R2 R3
            fourthOut_reg <= '{drv: latFourth_reg, oe: dirFourth_reg & {NIB{~inpReset}}};
        end
    end

    // ==========================================
    // pull-down and input gating
    always_ff @(posedge mclk) begin
        if (rst) begin
            pulldown_reg <= 1'b1; // R17 R18
            gate_reg     <= 1'b0;
        end else begin
            pulldown_reg <= 1'b1; // R17
            gate_reg     <= stopNow; // R12 R19
        end
    end

    assign prdata      = rdata_reg;
    assign pready      = ready_reg;
    assign pslverr     = err_reg;
    assign firstOut    = firstOut_reg;
    assign secondOut   = secondOut_reg;
    assign groupOut    = groupOut_reg;
    assign fourthOut   = fourthOut_reg;
    assign pulldownEn  = pulldown_reg;
    assign inputGateEn = gate_reg;
endmodule

// [verif/gpio_ports_checker.sv]
// checker: port-level properties of the general-purpose port block
module gpio_ports_checker
    import gpio_pkg::*;
(
    // clock and reset
    input wire logic                   mclk,
    input wire logic                   rst,
    // apb
    input wire logic                   psel,
    input wire logic                   penable,
    input wire logic                   pready,
    input wire logic                   pslverr,
    // events
    input wire logic                   ceReset,
    input wire logic                   clockStop,
    input wire logic                   haltState,
    // pads
    input wire gpio_pkg::gpio_pad_out_s firstOut,
    input wire gpio_pkg::gpio_pad_out_s secondOut,
    input wire gpio_pkg::gpio_pad_out_s groupOut,
    input wire gpio_pkg::gpio_pad_out_s fourthOut,
    input wire logic                   pulldownEn,
    input wire logic                   inputGateEn
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    gpio_nib_t allOe;
    assign allOe = firstOut.oe | secondOut.oe | groupOut.oe | fourthOut.oe;
    // ==========================================
    // properties
    reset_release_a : assert property ($past(rst) |-> allOe == 4'h0)
        else $error("pads driven after reset");
    ready_wait_a : assert property (psel && !penable |=> pready)
        else $error("ready not in first access cycle");
    pready_pulse_a : assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    err_ready_a : assert property (pslverr |-> pready)
        else $error("error without ready");
    group_whole_a : assert property (groupOut.oe == 4'h0 || groupOut.oe == 4'hf)
        else $error("group port split direction");
    stop_input_a : assert property (clockStop |-> ##[1:3] allOe == 4'h0)
        else $error("pads driven during stop");
    ce_input_a : assert property (ceReset |-> ##[1:3] allOe == 4'h0)
        else $error("pads driven after ce reset");
    halt_hold_a : assert property (haltState [*3] |-> $stable(firstOut) && $stable(fourthOut))
        else $error("pads changed in halt");
    pulldown_on_a : assert property (pulldownEn)
        else $error("pull-down released");
    gate_stop_a : assert property (clockStop |=> inputGateEn)
        else $error("input gating off in stop");
    cover property (pslverr);
    cover property (clockStop ##1 inputGateEn);
    cover property (haltState [*3]);
    cover property (ceReset);
endmodule

bind gpio_ports gpio_ports_checker chk_u (.mclk, .rst, .psel, .penable, .pready, .pslverr, .ceReset,
    .clockStop, .haltState, .firstOut, .secondOut, .groupOut, .fourthOut, .pulldownEn, .inputGateEn);

// [verif/gpio_pad_model.sv]
// partner: external circuitry on one nibble of pins
module gpio_pad_model
    import gpio_pkg::*;
(
    // clock
    input  wire logic                    mclk,
    // device side
    input  wire gpio_pkg::gpio_pad_out_s pad,
    input  wire logic                    pullDn,
    // scenario control
    input  wire gpio_pkg::gpio_nib_t     extEn,
    input  wire gpio_pkg::gpio_nib_t     extVal,
    // pin levels
    output gpio_pkg::gpio_nib_t          pin
);
    gpio_nib_t fltReg = 4'h5;
    always @(posedge mclk) begin
        fltReg <= ~fltReg;
    end
    // external driver wins, then device drive, then pull or toggling float
    assign pin = (extEn & extVal) | (~extEn & pad.oe & pad.drv)
               | (~extEn & ~pad.oe & ~{NIB{pullDn}} & fltReg);
endmodule

// [verif/gpio_ports_tb.sv]
// testbench: register-level tests of the general-purpose port block
module gpio_ports_tb
    import gpio_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    // ==========================================
    // signals
    logic          mclk, rst, psel, penable, pwrite, ceReset, clockStop, haltState;
    logic          pready, pslverr, pulldownEn, inputGateEn, e, boardPull;
    logic [9:0]    paddr;
    gpio_word_t    pwdata, prdata, q;
    gpio_pad_out_s firstOut, secondOut, groupOut, fourthOut;
    gpio_nib_t     firstIn, secondIn, groupIn, fourthIn, pulldownIn, plainIn;
    gpio_nib_t     xEn [6];
    gpio_nib_t     xVal [6];
    int            mismatches, cmp_count;
    localparam logic [9:0] A_GSEL = 10'h09c, A_D1 = 10'h0dc, A_D4 = 10'h018, A_P1 = 10'h000;
    localparam logic [9:0] A_P2 = 10'h004, A_P3 = 10'h008, A_P4 = 10'h00c, A_PD = 10'h010;
    localparam logic [9:0] A_PL = 10'h014, A_RMW = 10'h01c, A_D2 = 10'h0d8, A_CTRL = 10'h020;
    always #25 mclk = ~mclk;
    // ==========================================
    // design and pins
    gpio_ports dut_u (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ceReset, .clockStop, .haltState, .firstIn, .firstOut, .secondIn, .secondOut, .groupIn, .groupOut,
        .fourthIn, .fourthOut, .pulldownIn, .pulldownEn, .plainIn, .inputGateEn);
    gpio_pad_model m0_u (.mclk, .pad(firstOut), .pullDn(boardPull),
        .extEn(xEn[0]), .extVal(xVal[0]), .pin(firstIn));
    gpio_pad_model m1_u (.mclk, .pad(secondOut), .pullDn(boardPull),
        .extEn(xEn[1]), .extVal(xVal[1]), .pin(secondIn));
    gpio_pad_model m2_u (.mclk, .pad(groupOut), .pullDn(1'b1),
        .extEn(xEn[2]), .extVal(xVal[2]), .pin(groupIn));
    gpio_pad_model m3_u (.mclk, .pad(fourthOut), .pullDn(boardPull),
        .extEn(xEn[3]), .extVal(xVal[3]), .pin(fourthIn));
    gpio_pad_model m4_u (.mclk, .pad('0), .pullDn(pulldownEn),
        .extEn(xEn[4]), .extVal(xVal[4]), .pin(pulldownIn));
    gpio_pad_model m5_u (.mclk, .pad('0), .pullDn(boardPull),
        .extEn(xEn[5]), .extVal(xVal[5]), .pin(plainIn));
    // ==========================================
    // tasks
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input gpio_word_t got, input gpio_word_t exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [9:0] a, input gpio_word_t d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do begin
            @(posedge mclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            mismatches++;
            $display("[ERR] %0t bus timeout", $time);
            final_report();
        end
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic wr(input logic [9:0] a, input gpio_word_t d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [9:0] a, input gpio_word_t exp);
        apb(1'b0, a, 32'h0);
        chk(q, exp);
    endtask
    task automatic gap(input int n);
        repeat (n) @(posedge mclk);
    endtask
    // ==========================================
    // sequence
    initial begin
        mclk = 1'b0;
        {rst, psel, penable, pwrite, ceReset, clockStop, haltState, boardPull} <= 8'b10000000;
        paddr <= '0;
        pwdata <= '0;
        mismatches = 0;
        cmp_count = 0;
        for (int i = 0; i < 6; i++) begin
            xEn[i] = 4'h0;
            xVal[i] = 4'h0;
        end
        gap(10);
        rst <= 1'b0;
        gap(1);
        rd(A_GSEL, 32'h0);
        rd(A_D1, 32'h0);
        chk(32'(firstOut.oe | secondOut.oe | groupOut.oe | fourthOut.oe), 32'h0);
        chk(32'(pulldownEn), 32'h1);
        wr(A_GSEL, 32'hffff_ffff);
        rd(A_GSEL, 32'h1);
        wr(A_P3, 32'h9);
        gap(2);
        chk(32'(groupOut.oe), 32'hf);
        chk(32'(groupOut.drv), 32'h9);
        $display("test group done");
        wr(A_P1, 32'h5);
        xEn[1] <= 4'hf;
        xVal[1] <= 4'ha;
        gap(8);
        chk(32'(firstOut.oe), 32'h0);
        rd(A_P2, 32'ha);
        wr(A_D1, 32'hf);
        gap(2);
        chk(32'(firstOut.drv), 32'h5);
        chk(32'(firstOut.oe), 32'hf);
        $display("test direction done");
        wr(A_P4, 32'h6);
        wr(A_D4, 32'hf);
        wr(A_P1, 32'hf);
        xEn[3] <= 4'hf;
        xVal[3] <= 4'h9;
        xEn[0] <= 4'h4;
        gap(8);
        rd(A_P4, 32'h6);
        rd(A_P1, 32'hb);
        wr(A_RMW, 32'hf);
        xEn[0] <= 4'h0;
        gap(8);
        chk(32'(firstOut.drv), 32'hb);
        $display("test readback done");
        haltState <= 1'b1;
        gap(2);
        wr(A_P4, 32'h1);
        gap(2);
        chk(32'(fourthOut.drv), 32'h6);
        haltState <= 1'b0;
        gap(2);
        $display("test halt done");
        ceReset <= 1'b1;
        gap(1);
        ceReset <= 1'b0;
        gap(3);
        chk(32'(firstOut.oe | groupOut.oe), 32'h0);
        rd(A_D1, 32'h0);
        rd(A_GSEL, 32'h0);
        wr(A_D1, 32'hf);
        gap(2);
        chk(32'(firstOut.drv), 32'hb);
        $display("test ce reset done");
        xEn[4] <= 4'hf;
        xVal[4] <= 4'h3;
        xEn[5] <= 4'hf;
        xVal[5] <= 4'hc;
        wr(A_PD, 32'hf);
        wr(A_PL, 32'h0);
        gap(8);
        rd(A_PD, 32'h3);
        rd(A_PL, 32'hc);
        xEn[4] <= 4'h0;
        gap(8);
        rd(A_PD, 32'h0);
        $display("test inputs done");
        clockStop <= 1'b1;
        gap(4);
        chk(32'(firstOut.oe), 32'h0);
        chk(32'(inputGateEn), 32'h1);
        rd(A_PL, 32'h0);
        clockStop <= 1'b0;
        gap(3);
        rd(A_PL, 32'hc);
        $display("test stop done");
        wr(A_D2, 32'h3);
        rd(A_D2, 32'h3);
        wr(A_CTRL, 32'h6);
        wr(A_P2, 32'h3);
        rd(A_CTRL, 32'h6);
        rd(A_PL, 32'h0);
        chk(32'(secondOut), 32'h03);
        wr(A_CTRL, 32'h1);
        rd(A_D2, 32'h0);
        chk(32'(secondOut), 32'h00);
        $display("test control done");
        apb(1'b0, 10'h3fc, 32'h0);
        chk(32'(e), 32'h1);
        $display("test unmapped done");
        final_report();
    end
endmodule
